// *** common/uep_consts.svh ***
// Constants for the endpoint ping-pong transfer block.
// Assumes inclusion by bare name from package, design and testbench files.
`ifndef UEP_CONSTS_SVH
`define UEP_CONSTS_SVH
`define UEP_DATA_W 8
`define UEP_BANK_DEPTH 64
`define UEP_PTR_W 6
`define UEP_FIFO_DEPTH 16
`define UEP_HS_ACK 2'h1
`define UEP_HS_NAK 2'h2
`define UEP_HS_NONE 2'h0
`endif

// *** common/uep_pkg.sv ***
// Types for the endpoint ping-pong transfer block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "uep_consts.svh"
package uep_pkg;
  typedef logic [`UEP_DATA_W-1:0] uep_byte_type;
  typedef logic [1:0] uep_hs_type;
  typedef logic [`UEP_PTR_W:0] uep_len_type;
endpackage
`default_nettype wire

// *** common/uep_link_if.sv ***
// Link between the USB endpoint (device) and the host transaction engine.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface uep_link_if;
  import uep_pkg::*;
  // Host to device.
  logic inToken;
  logic outByteValid;
  uep_byte_type outByte;
  logic outLast;
  logic outIso;
  logic inTaken;
  // Device to host.
  logic inByteValid;
  uep_byte_type inByte;
  logic inLast;
  logic outReady;
  logic hsValid;
  uep_hs_type hsCode;
  modport device(input inToken, outByteValid, outByte, outLast, outIso, inTaken,
    output inByteValid, inByte, inLast, outReady, hsValid, hsCode);
  modport host(output inToken, outByteValid, outByte, outLast, outIso, inTaken,
    input inByteValid, inByte, inLast, outReady, hsValid, hsCode);
endinterface
`default_nettype wire

// *** design/uep_fifo.sv ***
// Parameterised valid/ready FIFO.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module uep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Fill side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic push, pop;
  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    outValid = (wrPtr_q != rdPtr_q);
    outData = mem[rdPtr_q[AW-1:0]];
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule
`default_nettype wire

// *** design/uep_device.sv ***
// USB endpoint device end: dual-bank IN sequencing and single-bank OUT handling.
// Assumes the host end drives the link on the same clock; firmware side is plain ports.
`timescale 1ns/1ps
`default_nettype none
`include "uep_consts.svh"
module uep_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link to the host.
  uep_link_if.device link,
  // Firmware IN path.
  input wire logic fwWrValid,
  input wire uep_pkg::uep_byte_type fwWrData,
  output logic fwWrReady,
  input wire logic fwSetTxReady,
  input wire logic fwClrTxComplete,
  output logic txPacketReady,
  output logic txComplete,
  output logic txIrq,
  output logic bank0Busy,
  output logic bank1Busy,
  // Firmware OUT path.
  input wire logic fwRxRelease,
  input wire logic fwRxRead,
  output logic rxPacketValid,
  output uep_pkg::uep_byte_type rxData,
  output logic rxDataValid,
  output logic rxOverIso
);
  import uep_pkg::*;
  typedef enum logic [1:0] {IN_IDLE, IN_SEND, IN_WAIT} uep_in_state_type;
  uep_byte_type bankMem [2][`UEP_BANK_DEPTH];
  uep_byte_type rxMem [`UEP_BANK_DEPTH];
  uep_in_state_type inSt_q, inSt_d;
  logic fillBank_q, fillBank_d, sendBank_q, sendBank_d;
  logic [1:0] filled_q, filled_d, ready_q, ready_d;
  uep_len_type fillLen_q [2];
  uep_len_type fillLen_d [2];
  uep_len_type txIdx_q, txIdx_d;
  logic tx_complete_flag_q, tx_complete_flag_d;
  logic inV_q, inV_d, inL_q, inL_d;
  uep_byte_type inB_q, inB_d;
  logic hsV_q, hsV_d;
  uep_hs_type hsC_q, hsC_d;
  logic rxOwn_q, rxOwn_d, rxDrop_q, rxDrop_d, iso_q, iso_d;
  uep_len_type rxLen_q, rxLen_d, rxIdx_q, rxIdx_d;
  logic rdV_q, rdV_d;
  uep_byte_type rd_q, rd_d;
  logic fifoValid, fifoReady;
  uep_byte_type fifoData;
  logic fillPush;
  logic wrRdy_q, wrRdy_d, pktRdy_q, pktRdy_d;

  // OUT bytes from the host pass through a FIFO before landing in the bank.
  uep_fifo #(.WIDTH(`UEP_DATA_W), .DEPTH(`UEP_FIFO_DEPTH)) rxFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(link.outByteValid),
    .inData(link.outByte),
    .inReady(fifoReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(1'b1)
  );

  always_comb begin
    fillPush = fwWrValid && !filled_q[fillBank_q] &&
      (fillLen_q[fillBank_q] < uep_len_type'(`UEP_BANK_DEPTH));
    fillBank_d = fillBank_q;
    filled_d = filled_q;
    ready_d = ready_q;
    fillLen_d = fillLen_q;
    sendBank_d = sendBank_q;
    inSt_d = inSt_q;
    txIdx_d = txIdx_q;
    tx_complete_flag_d = tx_complete_flag_q;
    inV_d = 1'b0;
    inL_d = 1'b0;
    inB_d = inB_q;
    hsV_d = 1'b0;
    hsC_d = `UEP_HS_NONE;
    if (fillPush) begin
      fillLen_d[fillBank_q] = fillLen_q[fillBank_q] + 1'b1;
    end
    // A ready strobe commits the bank being filled and moves filling to the other bank.
    if (fwSetTxReady && !filled_q[fillBank_q]) begin
      filled_d[fillBank_q] = 1'b1;
      ready_d[fillBank_q] = 1'b1;
      fillBank_d = !fillBank_q;
    end
    if (fwClrTxComplete) begin
      tx_complete_flag_d = 1'b0;
    end
    case (inSt_q)
      IN_IDLE: begin
        if (link.inToken) begin
          if (ready_q[sendBank_q]) begin
            inSt_d = IN_SEND;
            txIdx_d = '0;
          end else begin
            hsV_d = 1'b1;
            hsC_d = `UEP_HS_NAK;
          end
        end
      end
      IN_SEND: begin
        inV_d = 1'b1;
        inB_d = bankMem[sendBank_q][txIdx_q[`UEP_PTR_W-1:0]];
        inL_d = (txIdx_q + 1'b1 >= fillLen_q[sendBank_q]);
        txIdx_d = txIdx_q + 1'b1;
        if (inL_d) begin
          inSt_d = IN_WAIT;
        end
      end
      IN_WAIT: begin
        if (link.inTaken) begin
          inSt_d = IN_IDLE;
          filled_d[sendBank_q] = 1'b0;
          ready_d[sendBank_q] = 1'b0;
          fillLen_d[sendBank_q] = '0;
          tx_complete_flag_d = 1'b1;
          sendBank_d = !sendBank_q;
        end
      end
      default: inSt_d = IN_IDLE;
    endcase
    // OUT path: firmware owns the bank until it releases it.
    rxOwn_d = rxOwn_q;
    rxDrop_d = rxDrop_q;
    iso_d = iso_q;
    rxLen_d = rxLen_q;
    rxIdx_d = rxIdx_q;
    rdV_d = 1'b0;
    rd_d = rd_q;
    if (link.outByteValid && link.outIso) begin
      iso_d = 1'b1;
    end
    // The FIFO drains every cycle, so rxDrop_q tags the one byte it holds as isochronous.
    if (link.outByteValid) begin
      rxDrop_d = link.outIso;
    end
    if (fifoValid) begin
      if (!rxOwn_q && !rxDrop_q &&
          rxLen_q < uep_len_type'(`UEP_BANK_DEPTH)) begin
        rxLen_d = rxLen_q + 1'b1;
      end
    end
    if (link.outByteValid && link.outLast) begin
      hsV_d = 1'b1;
      if (rxOwn_q || link.outIso) begin
        hsC_d = `UEP_HS_NAK;
        rxLen_d = rxOwn_q ? rxLen_q : '0;
      end else begin
        hsC_d = `UEP_HS_ACK;
      end
    end
    // Ownership passes to firmware at the edge where the last accepted byte drains.
    if (!rxOwn_q && hsV_q && hsC_q == `UEP_HS_ACK) begin
      rxOwn_d = 1'b1;
      rxIdx_d = '0;
    end
    if (rxOwn_q && fwRxRead && rxIdx_q < rxLen_q) begin
      rdV_d = 1'b1;
      rd_d = rxMem[rxIdx_q[`UEP_PTR_W-1:0]];
      rxIdx_d = rxIdx_q + 1'b1;
    end
    if (rxOwn_q && fwRxRelease) begin
      rxOwn_d = 1'b0;
      rxLen_d = '0;
    end
    wrRdy_d = !filled_d[fillBank_d];
    pktRdy_d = |ready_d;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inSt_q <= IN_IDLE;
      fillBank_q <= 1'b0;
      sendBank_q <= 1'b0;
      filled_q <= 2'h0;
      ready_q <= 2'h0;
      fillLen_q[0] <= '0;
      fillLen_q[1] <= '0;
      txIdx_q <= '0;
      tx_complete_flag_q <= 1'b0;
      inV_q <= 1'b0;
      inL_q <= 1'b0;
      inB_q <= '0;
      hsV_q <= 1'b0;
      hsC_q <= `UEP_HS_NONE;
      rxOwn_q <= 1'b0;
      rxDrop_q <= 1'b0;
      iso_q <= 1'b0;
      rxLen_q <= '0;
      rxIdx_q <= '0;
      rdV_q <= 1'b0;
      rd_q <= '0;
      wrRdy_q <= 1'b1;
      pktRdy_q <= 1'b0;
    end else begin
      inSt_q <= inSt_d;
      fillBank_q <= fillBank_d;
      sendBank_q <= sendBank_d;
      filled_q <= filled_d;
      ready_q <= ready_d;
      fillLen_q <= fillLen_d;
      txIdx_q <= txIdx_d;
      tx_complete_flag_q <= tx_complete_flag_d;
      inV_q <= inV_d;
      inL_q <= inL_d;
      inB_q <= inB_d;
      hsV_q <= hsV_d;
      hsC_q <= hsC_d;
      rxOwn_q <= rxOwn_d;
      rxDrop_q <= rxDrop_d;
      iso_q <= iso_d;
      rxLen_q <= rxLen_d;
      rxIdx_q <= rxIdx_d;
      rdV_q <= rdV_d;
      rd_q <= rd_d;
      wrRdy_q <= wrRdy_d;
      pktRdy_q <= pktRdy_d;
    end
    if (fillPush) begin
      bankMem[fillBank_q][fillLen_q[fillBank_q][`UEP_PTR_W-1:0]] <= fwWrData;
    end
    if (fifoValid && !rxOwn_q && rxLen_q < uep_len_type'(`UEP_BANK_DEPTH)) begin
      rxMem[rxLen_q[`UEP_PTR_W-1:0]] <= fifoData;
    end
  end

  always_comb begin
    link.inByteValid = inV_q;
    link.inByte = inB_q;
    link.inLast = inL_q;
    link.outReady = fifoReady;
    link.hsValid = hsV_q;
    link.hsCode = hsC_q;
    fwWrReady = wrRdy_q;
    txPacketReady = pktRdy_q;
    txComplete = tx_complete_flag_q;
    txIrq = tx_complete_flag_q;
    bank0Busy = filled_q[0];
    bank1Busy = filled_q[1];
    rxPacketValid = rxOwn_q;
    rxData = rd_q;
    rxDataValid = rdV_q;
    rxOverIso = iso_q;
  end
endmodule
`default_nettype wire

// *** design/uep_host.sv ***
// Host end: issues IN tokens and OUT packets and reports handshakes.
// Assumes the device end shares the clock; the user side drives requests.
`timescale 1ns/1ps
`default_nettype none
`include "uep_consts.svh"
module uep_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link to the device.
  uep_link_if.host link,
  // User requests.
  input wire logic reqIn,
  input wire logic reqOutValid,
  input wire uep_pkg::uep_byte_type reqOutByte,
  input wire logic reqOutLast,
  input wire logic reqOutIso,
  input wire logic pingPongEp,
  // User answers.
  output logic rxValid,
  output uep_pkg::uep_byte_type rxByte,
  output logic rxLast,
  output logic hsSeen,
  output uep_pkg::uep_hs_type hsSeenCode
);
  import uep_pkg::*;
  logic tok_q, tok_d, taken_q, taken_d, ov_q, ov_d, ol_q, ol_d, iso_q, iso_d;
  uep_byte_type ob_q, ob_d;
  logic rv_q, rv_d, rl_q, rl_d, hv_q, hv_d;
  uep_byte_type rb_q, rb_d;
  uep_hs_type hc_q, hc_d;
  always_comb begin
    tok_d = reqIn;
    taken_d = link.inByteValid && link.inLast;
    // Isochronous OUT is only sent to ping-pong endpoints.
    ov_d = reqOutValid && link.outReady && (!reqOutIso || pingPongEp);
    ob_d = reqOutByte;
    ol_d = reqOutLast;
    iso_d = reqOutIso;
    rv_d = link.inByteValid;
    rb_d = link.inByte;
    rl_d = link.inLast;
    hv_d = link.hsValid;
    hc_d = link.hsCode;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tok_q <= 1'b0;
      taken_q <= 1'b0;
      ov_q <= 1'b0;
      ob_q <= '0;
      ol_q <= 1'b0;
      iso_q <= 1'b0;
      rv_q <= 1'b0;
      rb_q <= '0;
      rl_q <= 1'b0;
      hv_q <= 1'b0;
      hc_q <= `UEP_HS_NONE;
    end else begin
      tok_q <= tok_d;
      taken_q <= taken_d;
      ov_q <= ov_d;
      ob_q <= ob_d;
      ol_q <= ol_d;
      iso_q <= iso_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      rl_q <= rl_d;
      hv_q <= hv_d;
      hc_q <= hc_d;
    end
  end
  always_comb begin
    link.inToken = tok_q;
    link.inTaken = taken_q;
    link.outByteValid = ov_q;
    link.outByte = ob_q;
    link.outLast = ol_q;
    link.outIso = iso_q;
    rxValid = rv_q;
    rxByte = rb_q;
    rxLast = rl_q;
    hsSeen = hv_q;
    hsSeenCode = hc_q;
  end
endmodule
`default_nettype wire

// *** tb/uep_link_properties.sv ***
// Concurrent checks on the link between the host and device ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "uep_consts.svh"
module uep_link_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Host to device.
  input wire logic inToken,
  input wire logic outByteValid,
  input wire logic outLast,
  input wire logic outIso,
  input wire logic inTaken,
  // Device to host.
  input wire logic inByteValid,
  input wire logic inLast,
  input wire logic hsValid,
  input wire uep_pkg::uep_hs_type hsCode
);
  import uep_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence seqNak;
    hsValid && hsCode == `UEP_HS_NAK;
  endsequence
  sequence seqOutEnd;
    outByteValid && outLast;
  endsequence
  AST_IN_ANSWER: assert property (inToken |-> (##1 seqNak) or (##2 inByteValid))
    else $error("IN token got neither NAK nor data");
  AST_NAK_NO_DATA: assert property (inToken ##1 seqNak |=> !inByteValid)
    else $error("data sent after NAK");
  AST_OUT_ANSWER: assert property (seqOutEnd |-> ##1 hsValid
    && hsCode inside {`UEP_HS_ACK, `UEP_HS_NAK})
    else $error("OUT packet not answered");
  AST_ISO_NAK: assert property (seqOutEnd and outIso |-> ##1 seqNak)
    else $error("isochronous OUT accepted");
  AST_HS_PULSE: assert property (hsValid |=> !hsValid)
    else $error("handshake longer than one cycle");
  AST_HS_CAUSE: assert property (hsValid |-> $past(inToken) || $past(outByteValid && outLast))
    else $error("handshake without request");
  AST_IN_TAKEN: assert property (inByteValid && inLast |=> inTaken)
    else $error("last IN byte not taken");
  AST_TAKEN_END: assert property (inTaken |=> !inTaken && !inByteValid)
    else $error("IN data after packet taken");
  AST_NO_TOKEN_IN_DATA: assert property (inByteValid |-> !inToken)
    else $error("token during IN transfer");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench joining the host and device ends through the link.
// Assumes design, package and interface files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "uep_consts.svh"
module testbench;
  import uep_pkg::*;
  logic clk, reset_n, fwWrValid, fwSetTxReady, fwClrTxComplete, fwRxRelease, fwRxRead;
  logic reqIn, reqOutValid, reqOutLast, reqOutIso, pingPongEp, fwWrReady, txPacketReady;
  logic txComplete, txIrq, bank0Busy, bank1Busy, rxPacketValid, rxDataValid, rxOverIso;
  logic rxValid, rxLast, hsSeen;
  uep_byte_type fwWrData, reqOutByte, rxData, rxByte;
  uep_hs_type hsSeenCode;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  uep_link_if link();
  uep_device uep_device_inst(.clk, .reset_n, .link, .fwWrValid, .fwWrData, .fwWrReady,
    .fwSetTxReady, .fwClrTxComplete, .txPacketReady, .txComplete, .txIrq, .bank0Busy,
    .bank1Busy, .fwRxRelease, .fwRxRead, .rxPacketValid, .rxData, .rxDataValid, .rxOverIso);
  uep_host uep_host_inst(.clk, .reset_n, .link, .reqIn, .reqOutValid, .reqOutByte,
    .reqOutLast, .reqOutIso, .pingPongEp, .rxValid, .rxByte, .rxLast, .hsSeen, .hsSeenCode);
  uep_link_properties uep_link_properties_inst(.clk, .reset_n, .inToken(link.inToken),
    .outByteValid(link.outByteValid), .outLast(link.outLast), .outIso(link.outIso),
    .inTaken(link.inTaken), .inByteValid(link.inByteValid), .inLast(link.inLast),
    .hsValid(link.hsValid), .hsCode(link.hsCode));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nErrors++;
      completeRun();
    end
  end
  task automatic completeRun;
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic ok, string m);
    samplesChecked++;
    if (!ok) begin
      nErrors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step();
    s = 0;
  endtask
  task automatic waitSig(ref logic s);
    for (int i = 0; i < 100 && s !== 1; i++) step();
  endtask
  task automatic waitHs(uep_hs_type code);
    waitSig(hsSeen);
    chk(hsSeen === 1 && hsSeenCode === code, "handshake");
  endtask
  task automatic fill(uep_byte_type b, int n);
    for (int i = 0; i < n; i++) begin
      fwWrValid = 1;
      fwWrData = uep_byte_type'(b + i);
      step();
    end
    fwWrValid = 0;
  endtask
  task automatic getIn(uep_byte_type b, int n);
    int k = 0;
    pulse(reqIn);
    for (int i = 0; i < 200 && k < n; i++) begin
      if (rxValid === 1) begin
        chk(rxByte === uep_byte_type'(b + k) && rxLast === (k == n - 1), "IN byte");
        k++;
      end
      step();
    end
    chk(k == n, "IN count");
  endtask
  task automatic putOut(uep_byte_type b, int n, logic iso, uep_hs_type code);
    for (int i = 0; i < n; i++) begin
      reqOutValid = 1;
      reqOutByte = uep_byte_type'(b + i);
      reqOutLast = (i == n - 1);
      reqOutIso = iso;
      waitSig(link.outReady);
      step();
    end
    reqOutValid = 0;
    reqOutLast = 0;
    waitHs(code);
  endtask
  task automatic testNakIn;
    pulse(reqIn);
    waitHs(`UEP_HS_NAK);
  endtask
  task automatic testInPingPong;
    fill(8'h10, 3);
    pulse(fwSetTxReady);
    chk(bank0Busy === 1 && txPacketReady === 1 && fwWrReady === 1, "commit");
    fill(8'h20, 64);
    getIn(8'h10, 3);
    waitSig(txComplete);
    chk(txComplete === 1 && txIrq === 1 && bank0Busy === 0, "release");
    pulse(reqIn);
    waitHs(`UEP_HS_NAK);
    chk(txIrq === 1, "pending");
    pulse(fwSetTxReady);
    chk(bank1Busy === 1 && bank0Busy === 0 && fwWrReady === 1, "bank0 free");
    pulse(fwClrTxComplete);
    chk(txComplete === 0 && txIrq === 0, "cleared");
    fill(8'h70, 1);
    pulse(fwSetTxReady);
    getIn(8'h20, 64);
    getIn(8'h70, 1);
  endtask
  task automatic testOut;
    putOut(8'h40, 20, 0, `UEP_HS_ACK);
    chk(rxPacketValid === 1, "owned");
    putOut(8'h90, 2, 0, `UEP_HS_NAK);
    for (int i = 0; i < 20; i++) begin
      pulse(fwRxRead);
      waitSig(rxDataValid);
      chk(rxData === uep_byte_type'(8'h40 + i), "OUT byte");
    end
    pulse(fwRxRelease);
    pingPongEp = 1;
    putOut(8'hA0, 2, 1, `UEP_HS_NAK);
    chk(rxOverIso === 1 && rxPacketValid === 0, "iso");
  endtask
  task automatic testIsoBlocked;
    int seen = 0;
    pingPongEp = 0;
    reqOutIso = 1;
    reqOutValid = 1;
    reqOutLast = 1;
    for (int i = 0; i < 4; i++) begin
      step();
      if (link.outByteValid === 1 || hsSeen === 1) seen++;
    end
    reqOutValid = 0;
    reqOutLast = 0;
    reqOutIso = 0;
    step(3);
    chk(seen == 0 && hsSeen === 0, "iso sent to single bank");
  endtask
  initial begin
    {fwWrValid, fwSetTxReady, fwClrTxComplete, fwRxRelease, fwRxRead} = 5'h0;
    {reqIn, reqOutValid, reqOutLast, reqOutIso, pingPongEp} = 5'h0;
    fwWrData = 8'h0;
    reqOutByte = 8'h0;
    reset_n = 0;
    step(5);
    reset_n = 1;
    step();
    testNakIn();
    testInPingPong();
    testOut();
    testIsoBlocked();
    completeRun();
  end
endmodule
`default_nettype wire
